/* design/io_instruction_sequencer.sv */
/*
  Phase sequencer for start, halt, test and test-device I/O instructions,
  with an AHB-Lite register slave and per-subchannel FS/OF/IS/byte-count store.
  Assumes single-word AHB transfers, memory and controller synchronous to REF_CLK.
*/
`timescale 1ns/1ps
`include "io_seq_map.svh"
module io_instruction_sequencer (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic [7:0] FUNCTION_RESPONSE_LINES,
   input wire logic ADDR_RECOGNIZED,
   input wire logic START_ACCEPTED,
   input wire logic CPU_PROCEED_PENDING,
   input wire logic MEMORY_DONE_FLAG,
   input wire logic MEMORY_PARITY_ERROR,
   input wire logic [31:0] MEMORY_RDATA,
   output logic [7:0] CTRL_DATA_OUT,
   output logic START_IO_INSTR,
   output logic HALT_IO_INSTR,
   output logic TEST_IO_INSTR,
   output logic TEST_DEVICE_INSTR,
   output logic MEMORY_START,
   output logic MEMORY_WRITE,
   output logic MEMORY_WORD_SEL,
   output logic [3:0] FULL_WRITE_SELECT,
   output logic [31:0] MEMORY_WDATA,
   output logic SUBCHANNEL_RELEASE
);
   io_seq_pkg::phase_t st_r;
   io_seq_pkg::phase_t st_nxt;
   tap_if tif();
   logic [4:0] tap;
   logic [2:0] fcode_r;
   logic fen_r;
   logic [2:0] sub_sel_r;
   logic [7:0] a_r;
   logic [15:0] c_r;
   logic [7:0] h_r;
   logic [31:0] m_r;
   logic cmd_r;
   logic tpe_r;
   logic out_r;
   logic cc1_r;
   logic cc2_r;
   logic mpe_r;
   logic sel2_r;
   logic accept_r;
   logic pend_r;
   logic wr_pend_r;
   logic [7:0] waddr_r;
   logic go;
   logic addr_ok;
   logic cc_clear;
   logic [15:0] fs_mem [0:7];
   logic [15:0] bc_mem [0:7];
   logic [7:0] of_mem [0:7];
   logic [7:0] is_mem [0:7];

   assign tap = tif.tap;
   assign addr_ok = HSEL && HTRANS[1] && HREADY;
   assign go = wr_pend_r && (waddr_r == `OFS_CTRL) && HWDATA[`CTRL_GO];
   assign cc_clear = !cc1_r && !cc2_r;

   phase_tap_timer u_timer (
      .clk(REF_CLK),
      .rst(RESET),
      .tif(tif)
   );

   // Zero-wait slave: read data is fetched in the address phase
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         HRDATA <= 32'h0000_0000;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         wr_pend_r <= 1'b0;
         waddr_r <= 8'h00;
      end else begin
         wr_pend_r <= addr_ok && HWRITE;
         waddr_r <= HADDR[7:0];
         HRDATA <= 32'h0000_0000;
         if (addr_ok && !HWRITE) begin
            case (HADDR[7:0])
               `OFS_CTRL: HRDATA <= {28'h000_0000, fen_r, fcode_r};
               `OFS_STATUS: HRDATA <= {20'h0_0000, st_r, pend_r, accept_r, tpe_r, cmd_r,
                                       cc2_r, cc1_r, SUBCHANNEL_RELEASE, st_r != io_seq_pkg::IDLE};
               `OFS_SUB_SEL: HRDATA <= {29'h0000_0000, sub_sel_r};
               `OFS_SUB_FS: HRDATA <= {16'h0000, fs_mem[sub_sel_r]};
               `OFS_SUB_BC: HRDATA <= {16'h0000, bc_mem[sub_sel_r]};
               `OFS_SUB_ISOF: HRDATA <= {16'h0000, is_mem[sub_sel_r], of_mem[sub_sel_r]};
               default: HRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         fcode_r <= 3'h0;
         fen_r <= 1'b0;
         sub_sel_r <= 3'h0;
      end else if (wr_pend_r) begin
         if (waddr_r == `OFS_CTRL) begin
            fcode_r <= HWDATA[2:0];
            fen_r <= HWDATA[`CTRL_FEN];
         end
         if (waddr_r == `OFS_SUB_SEL) begin
            sub_sel_r <= HWDATA[2:0];
         end
      end
   end

   // Phase order; timed phases chain on the last tap
   always_comb begin
      st_nxt = st_r;
      tif.start = 1'b0;
      case (st_r)
         io_seq_pkg::IDLE: if (go) st_nxt = io_seq_pkg::PH1;
         io_seq_pkg::PH1: if (SUBCHANNEL_RELEASE) st_nxt = io_seq_pkg::PH2;
         io_seq_pkg::PH2: st_nxt = io_seq_pkg::PH2W;
         io_seq_pkg::PH2W: begin
            if (MEMORY_DONE_FLAG) begin
               st_nxt = io_seq_pkg::PH10;
               tif.start = 1'b1;
            end
         end
         io_seq_pkg::PH10: begin
            if (tap[4]) begin
               st_nxt = cmd_r ? io_seq_pkg::PH11 : io_seq_pkg::PH12;
               tif.start = 1'b1;
            end
         end
         io_seq_pkg::PH11: begin
            if (tap[4]) begin
               st_nxt = io_seq_pkg::PH12;
               tif.start = 1'b1;
            end
         end
         io_seq_pkg::PH12, io_seq_pkg::PH13: begin
            if (tap[4]) begin
               st_nxt = (st_r == io_seq_pkg::PH12) ? io_seq_pkg::PH13 : io_seq_pkg::PH14;
               tif.start = 1'b1;
            end
         end
         // A go landing on the last tap still counts as queued
         io_seq_pkg::PH14: if (tap[4]) st_nxt = (pend_r || (go && accept_r)) ? io_seq_pkg::PH1 : io_seq_pkg::IDLE;
         default: st_nxt = io_seq_pkg::IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         st_r <= io_seq_pkg::IDLE;
         accept_r <= 1'b0;
         pend_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (st_r == io_seq_pkg::PH12 && tap[4]) begin
            accept_r <= 1'b1;
         end else if (st_nxt == io_seq_pkg::IDLE || st_nxt == io_seq_pkg::PH1) begin
            accept_r <= 1'b0;
         end
         if (st_r == io_seq_pkg::PH14 && tap[4]) begin
            pend_r <= 1'b0;
         end else if (go && accept_r) begin
            pend_r <= 1'b1;
         end
      end
   end

   // Indicator lines: decoded on entry, dropped after the condition code
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         START_IO_INSTR <= 1'b0;
         HALT_IO_INSTR <= 1'b0;
         TEST_IO_INSTR <= 1'b0;
         TEST_DEVICE_INSTR <= 1'b0;
         out_r <= 1'b0;
      end else if (st_r == io_seq_pkg::PH2) begin
         // Decode disabled: no line and non-start, never a stale kind
         HALT_IO_INSTR <= fen_r && fcode_r == `FN_HALT;
         TEST_IO_INSTR <= fen_r && fcode_r == `FN_TEST;
         TEST_DEVICE_INSTR <= fen_r && fcode_r == `FN_TDEV;
         START_IO_INSTR <= fen_r && fcode_r != `FN_HALT && fcode_r != `FN_TEST && fcode_r != `FN_TDEV;
         out_r <= fen_r && fcode_r != `FN_HALT && fcode_r != `FN_TEST && fcode_r != `FN_TDEV;
      end else if (st_r == io_seq_pkg::PH12 && tap[2]) begin
         START_IO_INSTR <= 1'b0;
         HALT_IO_INSTR <= 1'b0;
         TEST_IO_INSTR <= 1'b0;
         TEST_DEVICE_INSTR <= 1'b0;
      end
   end

   // Condition flags start set; the controller clears them on success
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         cc1_r <= 1'b0;
         cc2_r <= 1'b0;
      end else if (st_r == io_seq_pkg::PH2) begin
         cc1_r <= 1'b1;
         cc2_r <= 1'b1;
      end else if (st_r == io_seq_pkg::PH12 && tap[1]) begin
         if (ADDR_RECOGNIZED) cc1_r <= 1'b0;
         if (START_ACCEPTED) cc2_r <= 1'b0;
      end
   end

   // Datapath registers A, O, C, H, M and the enables
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         a_r <= 8'h00;
         CTRL_DATA_OUT <= 8'h00;
         c_r <= 16'h0000;
         h_r <= 8'h00;
         m_r <= 32'h0000_0000;
         cmd_r <= 1'b0;
         tpe_r <= 1'b0;
         sel2_r <= 1'b0;
      end else begin
         if (st_r == io_seq_pkg::PH2W && MEMORY_DONE_FLAG) begin
            m_r <= MEMORY_RDATA;
            sel2_r <= 1'b1;
         end
         if (st_r == io_seq_pkg::PH10 && tap[0]) begin
            CTRL_DATA_OUT <= m_r[31:24];
            a_r <= m_r[31:24];
            cmd_r <= m_r[`M_BIT8];
            tpe_r <= m_r[`M_BIT9];
         end
         if (st_r == io_seq_pkg::PH11 && tap[1]) begin
            // Start keeps the new command address, others the saved status
            c_r <= out_r ? m_r[15:0] : fs_mem[a_r[2:0]];
            if (!out_r) begin
               m_r[15:0] <= fs_mem[a_r[2:0]];
            end
         end
         if (st_r == io_seq_pkg::PH12) begin
            if (tap[0]) begin
               m_r <= 32'h0000_0000;
            end else if (tap[1]) begin
               m_r <= {FUNCTION_RESPONSE_LINES, fs_mem[a_r[2:0]][7:0], bc_mem[a_r[2:0]]};
            end
         end
         if (st_r == io_seq_pkg::PH13) begin
            if (tap[0]) begin
               c_r <= {8'h00, fs_mem[a_r[2:0]][`FS_STAT_HI:`FS_STAT_LO], 1'b0};
               h_r <= {4'h0, a_r[3:0]};
            end
            if (tap[2] && out_r) begin
               m_r[31:16] <= c_r;
            end
            if (tap[4]) begin
               c_r <= 16'h0000;
               h_r <= 8'h00;
               sel2_r <= 1'b0;
            end
         end
         if (st_r == io_seq_pkg::PH14 && tap[4]) begin
            c_r <= 16'h0000;
         end
      end
   end

   // Memory requests stay up until the memory reports done
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         MEMORY_START <= 1'b0;
         MEMORY_WRITE <= 1'b0;
         MEMORY_WORD_SEL <= `WORD_X20;
         FULL_WRITE_SELECT <= 4'h0;
         mpe_r <= 1'b0;
      end else begin
         if (st_r == io_seq_pkg::PH2) begin
            MEMORY_START <= 1'b1;
            MEMORY_WRITE <= 1'b0;
            MEMORY_WORD_SEL <= `WORD_X20;
            FULL_WRITE_SELECT <= 4'h0;
            mpe_r <= 1'b0;
         end else if (st_r == io_seq_pkg::PH11 && tap[2]) begin
            MEMORY_START <= 1'b1;
            MEMORY_WRITE <= 1'b1;
            MEMORY_WORD_SEL <= `WORD_X20;
         end else if (st_r == io_seq_pkg::PH12 && tap[2] && tpe_r && !out_r) begin
            MEMORY_START <= 1'b1;
            MEMORY_WRITE <= 1'b1;
            MEMORY_WORD_SEL <= `WORD_X21;
         end else if (st_r == io_seq_pkg::PH13 && tap[2] && out_r && tpe_r && !CPU_PROCEED_PENDING && !mpe_r) begin
            MEMORY_START <= 1'b1;
            MEMORY_WRITE <= 1'b1;
            MEMORY_WORD_SEL <= `WORD_X21;
         end else if (MEMORY_DONE_FLAG) begin
            MEMORY_START <= 1'b0;
         end
         if (st_r == io_seq_pkg::PH10 && tap[0]) begin
            FULL_WRITE_SELECT <= `FULL_WORD;
         end
         if (MEMORY_START && MEMORY_PARITY_ERROR) begin
            mpe_r <= 1'b1;
         end
      end
   end

   assign MEMORY_WDATA = m_r;

   // Release: set late in phase 14, taken back when the next access begins
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         SUBCHANNEL_RELEASE <= 1'b1;
      end else if (st_r == io_seq_pkg::PH14 && tap[2]) begin
         SUBCHANNEL_RELEASE <= 1'b1;
      end else if (st_r == io_seq_pkg::PH2) begin
         SUBCHANNEL_RELEASE <= 1'b0;
      end
   end

   // Subchannel store; software preset wins only while idle
   always_ff @(posedge REF_CLK) begin
      if (out_r && cc_clear && st_r == io_seq_pkg::PH13 && tap[2]) begin
         is_mem[a_r[2:0]] <= {4'h0, h_r[3:0]};
      end
      if (out_r && cc_clear && st_r == io_seq_pkg::PH14 && tap[1]) begin
         fs_mem[a_r[2:0]] <= c_r;
         of_mem[a_r[2:0]] <= h_r;
      end
      if (wr_pend_r && st_r == io_seq_pkg::IDLE) begin
         if (waddr_r == `OFS_SUB_FS) fs_mem[sub_sel_r] <= HWDATA[15:0];
         if (waddr_r == `OFS_SUB_BC) bc_mem[sub_sel_r] <= HWDATA[15:0];
         if (waddr_r == `OFS_SUB_ISOF) begin
            is_mem[sub_sel_r] <= HWDATA[15:8];
            of_mem[sub_sel_r] <= HWDATA[7:0];
         end
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);

   property p_status_to_c;
      st_r == io_seq_pkg::PH13 && tap[0] |=> c_r == {8'h00, $past(fs_mem[a_r[2:0]][7:1]), 1'b0};
   endproperty
   a_status_to_c: assert property (p_status_to_c) else $error("status not moved into C");
   property p_addr_to_h;
      st_r == io_seq_pkg::PH13 && tap[0] |=> h_r[3:0] == a_r[3:0] ##2 h_r[3:0] == a_r[3:0];
   endproperty
   a_addr_to_h: assert property (p_addr_to_h) else $error("device address not in H");
   property p_adder_to_m;
      st_r == io_seq_pkg::PH13 && tap[2] && out_r |=> m_r[31:16] == {8'h00, c_r[7:0]};
   endproperty
   a_adder_to_m: assert property (p_adder_to_m) else $error("second word not assembled");
   property p_second_store;
      st_r == io_seq_pkg::PH13 && tap[2] && !MEMORY_START && !(out_r && tpe_r && !CPU_PROCEED_PENDING && !mpe_r)
      |=> !MEMORY_START;
   endproperty
   a_second_store: assert property (p_second_store) else $error("store started without enables");
   property p_phase13_end;
      st_r == io_seq_pkg::PH13 && tap[4] |-> tif.start ##1 (st_r == io_seq_pkg::PH14 && c_r == 16'h0000
      && h_r == 8'h00 && !sel2_r);
   endproperty
   a_phase13_end: assert property (p_phase13_end) else $error("phase 13 did not close");
   property p_release;
      st_r == io_seq_pkg::PH14 && tap[2] |=> SUBCHANNEL_RELEASE [*2];
   endproperty
   a_release: assert property (p_release) else $error("release flag not set");
   property p_c_cleared;
      st_r == io_seq_pkg::PH14 && tap[4] |=> c_r == 16'h0000;
   endproperty
   a_c_cleared: assert property (p_c_cleared) else $error("C not cleared");
   property p_ph10_wait;
      st_r == io_seq_pkg::PH2W && !MEMORY_DONE_FLAG |=> st_r == io_seq_pkg::PH2W && !tap[0];
   endproperty
   a_ph10_wait: assert property (p_ph10_wait) else $error("phase 10 began before memory");
   property p_full_write;
      st_r == io_seq_pkg::PH10 && tap[0] |=> FULL_WRITE_SELECT == `FULL_WORD && CTRL_DATA_OUT == $past(m_r[31:24]);
   endproperty
   a_full_write: assert property (p_full_write) else $error("write select or address wrong");
   property p_drop_ind;
      st_r == io_seq_pkg::PH12 && tap[2] |=> !START_IO_INSTR && !HALT_IO_INSTR && !TEST_IO_INSTR;
   endproperty
   a_drop_ind: assert property (p_drop_ind) else $error("indicator not dropped");
endmodule

/* design/io_seq_map.svh */
/*
  Offsets, field positions and timing counts of the instruction sequencer.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef IO_SEQ_MAP_SVH
`define IO_SEQ_MAP_SVH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_SUB_SEL 8'h08
`define OFS_SUB_FS 8'h0C
`define OFS_SUB_BC 8'h10
`define OFS_SUB_ISOF 8'h14
`define CTRL_FEN 3
`define CTRL_GO 4
`define TAP_LAST 3'h4
`define M_BIT8 23
`define M_BIT9 22
`define FS_STAT_HI 7
`define FS_STAT_LO 1
`define FULL_WORD 4'hF
`define FN_HALT 3'h6
`define FN_TEST 3'h4
`define FN_TDEV 3'h2
`define WORD_X20 1'h0
`define WORD_X21 1'h1
`endif

/* design/io_seq_pkg.sv */
/*
  Types shared by the sequencer modules.
  Assumes nothing of its surroundings.
*/
package io_seq_pkg;
   typedef enum logic [3:0] {
      IDLE = 4'h0, PH1 = 4'h1, PH2 = 4'h3, PH2W = 4'h2, PH10 = 4'h6,
      PH11 = 4'h7, PH12 = 4'h5, PH13 = 4'h4, PH14 = 4'hC
   } phase_t;
endpackage

/* design/phase_tap_timer.sv */
/*
  Delay-line stand-in: one start pulse gives taps T0..T4, one cycle each.
  Assumes a synchronous active-high reset on the shared clock.
*/
`timescale 1ns/1ps
`include "io_seq_map.svh"
module phase_tap_timer (
   input wire logic clk,
   input wire logic rst,
   tap_if.timer tif
);
   logic run_r;
   logic [2:0] cnt_r;

   // A start at the last tap restarts at once, so phases chain with no gap
   always_ff @(posedge clk) begin
      if (rst) begin
         run_r <= 1'b0;
         cnt_r <= 3'h0;
      end else if (tif.start) begin
         run_r <= 1'b1;
         cnt_r <= 3'h0;
      end else if (run_r) begin
         if (cnt_r == `TAP_LAST) begin
            run_r <= 1'b0;
         end else begin
            cnt_r <= cnt_r + 3'h1;
         end
      end
   end

   genvar i;
   generate
      for (i = 0; i < 5; i++) begin : g_tap
         assign tif.tap[i] = run_r && (cnt_r == 3'(i));
      end
   endgenerate

   property p_tap_chain;
      @(posedge clk) disable iff (rst)
      tif.start |=> tif.tap[0] ##1 tif.tap[1] ##1 tif.tap[2] ##1 tif.tap[3] ##1 tif.tap[4];
   endproperty
   a_tap_chain: assert property (p_tap_chain) else $error("tap sequence broken");
endmodule

/* design/tap_if.sv */
/*
  Start request and tap pulses between the sequencer and its phase timer.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface tap_if;
   logic start;
   logic [4:0] tap;
   modport owner(output start, input tap);
   modport timer(input start, output tap);
endinterface

/* test/io_far_model.sv */
/*
  Far-side model: core memory and device controller facing the sequencer.
  Assumes the bench sets the config variables before each go request.
*/
`timescale 1ns/1ps
module io_far_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic ms,
   input wire logic mw,
   input wire logic wsl,
   input wire logic [3:0] wsel,
   input wire logic [31:0] wdata,
   input wire logic [3:0] ind,
   output logic done,
   output logic perr,
   output logic [31:0] rdata,
   output logic [7:0] fr,
   output logic ar,
   output logic sa
);
   logic [31:0] rd_word = 32'h0;
   int rd_delay = 1;
   logic perr_en = 1'b0;
   logic [7:0] fr_val = 8'h00;
   logic ar_val = 1'b0;
   logic sa_val = 1'b0;
   int reads = 0;
   int wr_cnt [2] = '{0, 0};
   logic [31:0] wr_word [2];
   logic [3:0] wr_sel [2];
   logic [3:0] ind_seen = 4'h0;
   int wait_n = 0;
   logic served = 1'b0;
   // Idle rdata and fr show the inverse so a stale value cannot pass; ar and sa read low
   assign rdata = done ? rd_word : ~rd_word;
   assign fr = |ind ? fr_val : ~fr_val;
   assign ar = |ind & ar_val;
   assign sa = |ind & sa_val;
   assign perr = perr_en & ms & ~mw;
   always @(posedge clk) begin
      done <= 1'b0;
      if (ms && !mw && !served && wait_n == 0)
         ind_seen <= ind;
      else
         ind_seen <= ind_seen | ind;
      if (rst || !ms) begin
         wait_n <= 0;
         served <= 1'b0;
      end else if (!served && wait_n + 1 >= (mw ? 1 : rd_delay)) begin
         done <= 1'b1;
         served <= 1'b1;
         if (mw) begin
            wr_cnt[wsl] <= wr_cnt[wsl] + 1;
            wr_word[wsl] <= wdata;
            wr_sel[wsl] <= wsel;
         end else begin
            reads <= reads + 1;
         end
      end else if (!served) begin
         wait_n <= wait_n + 1;
      end
   end
endmodule

/* test/tb_io_instruction_sequencer.sv */
/*
  Self-checking bench: AHB-Lite register tasks and instruction scenarios.
  Assumes the zero-wait register slave and the far-side model.
*/
`timescale 1ns/1ps
`include "io_seq_map.svh"
`define CHK(g, e) begin \
   checked++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("Error at %0t: got %h expected %h", $time, g, e); \
   end \
end
module tb_io_instruction_sequencer;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic proceed = 1'b0;
   logic [31:0] hrdata, rdata, wdata;
   logic hreadyout, hresp, ar, sa, done, perr, ms, mw, wsl, rel;
   logic st_o, hl_o, ts_o, td_o;
   logic [7:0] fr, ctrl_out;
   logic [3:0] wsel;
   int errors = 0;
   int checked = 0;
   int c20, c21, r, i;
   logic [31:0] v;
   logic [2:0] codes [4] = '{`FN_HALT, `FN_TEST, `FN_TDEV, `FN_HALT};
   logic [3:0] inds [4] = '{4'h4, 4'h2, 4'h1, 4'h0};

   io_instruction_sequencer u_dut (
      .REF_CLK(ref_clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp), .FUNCTION_RESPONSE_LINES(fr), .ADDR_RECOGNIZED(ar),
      .START_ACCEPTED(sa), .CPU_PROCEED_PENDING(proceed),
      .MEMORY_DONE_FLAG(done), .MEMORY_PARITY_ERROR(perr),
      .MEMORY_RDATA(rdata), .CTRL_DATA_OUT(ctrl_out),
      .START_IO_INSTR(st_o), .HALT_IO_INSTR(hl_o), .TEST_IO_INSTR(ts_o),
      .TEST_DEVICE_INSTR(td_o), .MEMORY_START(ms), .MEMORY_WRITE(mw),
      .MEMORY_WORD_SEL(wsl), .FULL_WRITE_SELECT(wsel),
      .MEMORY_WDATA(wdata), .SUBCHANNEL_RELEASE(rel)
   );
   io_far_model u_far (
      .clk(ref_clk), .rst(reset), .ms(ms), .mw(mw), .wsl(wsl),
      .wsel(wsel), .wdata(wdata), .ind({st_o, hl_o, ts_o, td_o}),
      .done(done), .perr(perr), .rdata(rdata), .fr(fr), .ar(ar), .sa(sa)
   );

   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Ready sampled just before the edge, so no race with the slave
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      logic rdy;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      n = 0;
      rdy = 1'b0;
      while (!rdy && n < 20) begin
         @(negedge ref_clk);
         rdy = hreadyout === 1'b1;
         @(posedge ref_clk);
         n++;
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy = 1'b0;
      while (!rdy && n < 40) begin
         @(negedge ref_clk);
         rdy = hreadyout === 1'b1;
         q = hrdata;
         @(posedge ref_clk);
         n++;
      end
      if (!rdy) begin
         errors++;
         tally_and_finish();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask

   task automatic wait_idle();
      logic [31:0] s;
      int n;
      s = 32'h1;
      for (n = 0; n < 150 && (s & 32'h81) !== 32'h0; n++)
         rd(`OFS_STATUS, s);
      if ((s & 32'h81) !== 32'h0) begin
         errors++;
         tally_and_finish();
      end
   endtask

   task automatic preset(input logic [2:0] sub);
      wr(`OFS_SUB_SEL, {29'h0, sub});
      wr(`OFS_SUB_FS, 32'h3CB5);
      wr(`OFS_SUB_BC, 32'h1234);
      wr(`OFS_SUB_ISOF, 32'hA7C3);
   endtask

   task automatic go(input logic [2:0] code, input logic fen, input logic [31:0] w20);
      u_far.rd_word = w20;
      c20 = u_far.wr_cnt[0];
      c21 = u_far.wr_cnt[1];
      wr(`OFS_CTRL, {27'h0, 1'b1, fen, code});
      wait_idle();
   endtask

   task automatic check_sub(input logic [31:0] fs, input logic [31:0] isof);
      logic [31:0] q;
      rd(`OFS_SUB_FS, q);
      `CHK(q, fs)
      rd(`OFS_SUB_ISOF, q);
      `CHK(q, isof)
      rd(`OFS_SUB_BC, q);
      `CHK(q, 32'h1234)
   endtask

   initial begin
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      `CHK(hreadyout, 1'b1)
      `CHK(hresp, 1'b0)
      `CHK(rel, 1'b1)
      rd(`OFS_STATUS, v);
      `CHK(v, 32'h2)
      rd(8'h40, v);
      `CHK(v, 32'h0)
      // Successful start, second word only
      preset(3'h5);
      u_far.ar_val = 1'b1;
      u_far.sa_val = 1'b1;
      u_far.fr_val = 8'h9E;
      go(3'h0, 1'b1, 32'h3540_0000);
      `CHK(u_far.ind_seen, 4'h8)
      `CHK(ctrl_out, 8'h35)
      `CHK(u_far.wr_cnt[0] - c20, 0)
      `CHK(u_far.wr_cnt[1] - c21, 1)
      `CHK(u_far.wr_word[1], 32'h00B4_1234)
      `CHK(u_far.wr_sel[1], `FULL_WORD)
      rd(`OFS_STATUS, v);
      `CHK(v[5:1], 5'b10001)
      check_sub(32'h0, 32'h0500);
      // Address not recognized by controller, first word only
      preset(3'h5);
      u_far.ar_val = 1'b0;
      go(3'h0, 1'b1, 32'h3580_0000);
      `CHK(u_far.wr_cnt[0] - c20, 1)
      `CHK(u_far.wr_cnt[1] - c21, 0)
      `CHK(u_far.wr_sel[0], `FULL_WORD)
      `CHK(u_far.wr_word[0], 32'h3580_0000)
      rd(`OFS_STATUS, v);
      `CHK(v[5:2], 4'b0101)
      check_sub(32'h3CB5, 32'hA7C3);
      // Halt, test, test-device, then decode disabled
      for (i = 0; i < 4; i++) begin
         preset(3'h5);
         u_far.ar_val = 1'b1;
         u_far.fr_val = 8'h5A;
         go(codes[i], i < 3, 32'h35C0_0000);
         `CHK(u_far.ind_seen, inds[i])
         `CHK(u_far.wr_cnt[0] - c20, 1)
         `CHK(u_far.wr_word[0], 32'h35C0_3CB5)
         `CHK(u_far.wr_cnt[1] - c21, 1)
         rd(`OFS_STATUS, v);
         if (i < 3) begin
            `CHK(u_far.wr_word[1], 32'h5AB5_1234)
            `CHK(v[3:2], 2'b00)
         end
         check_sub(32'h3CB5, 32'hA7C3);
      end
      // Second word held back by proceed, then by parity error
      for (i = 0; i < 2; i++) begin
         preset(3'h5);
         proceed <= (i == 0);
         u_far.perr_en = (i == 1);
         go(3'h0, 1'b1, 32'h3540_0000);
         `CHK(u_far.wr_cnt[1] - c21, 0)
         check_sub(32'h0, 32'h0500);
      end
      proceed <= 1'b0;
      u_far.perr_en = 1'b0;
      // Slow memory: phase 10 must wait for the read
      preset(3'h2);
      u_far.rd_delay = 20;
      u_far.rd_word = 32'h6200_0000;
      wr(`OFS_CTRL, 32'h18);
      rd(`OFS_STATUS, v);
      rd(`OFS_STATUS, v);
      `CHK(v[11:8], 4'h2)
      `CHK(v[1], 1'b0)
      `CHK(rel, 1'b0)
      wait_idle();
      u_far.rd_delay = 1;
      `CHK(ctrl_out, 8'h62)
      `CHK(rel, 1'b1)
      // Next operation queued during the tail phases
      preset(3'h5);
      r = u_far.reads;
      u_far.rd_word = 32'h3540_0000;
      wr(`OFS_CTRL, 32'h18);
      v = 32'h0;
      for (i = 0; i < 60 && v[6] !== 1'b1; i++)
         rd(`OFS_STATUS, v);
      `CHK(v[6], 1'b1)
      wr(`OFS_CTRL, 32'h18);
      wait_idle();
      `CHK(u_far.reads - r, 2)
      `CHK(rel, 1'b1)
      tally_and_finish();
   end
endmodule
